/* File: hdl/rsm_pkg.sv */
/*
  shared constants and types of the resilient secure-messaging block.
  assumes one card clock; the frame layer and crypto engine sit outside.
*/
package rsm_pkg;

  localparam int BLK_BYTES = 16;
  localparam int CAP_BYTES = 6;
  localparam int TAG_BYTES = 4;
  localparam int CTR_W = 32;
  localparam int CMD_CTR_W = 16;
  localparam int KEY_W = 4;

  localparam logic [CTR_W-1:0] CTR_RESET = 32'h0000_0000;
  localparam logic [CTR_W-1:0] CTR_STEP = 32'h0000_0001;
  localparam logic [CMD_CTR_W-1:0] CMD_CTR_RESET = 16'h0000;
  localparam logic [TAG_BYTES*8-1:0] TAG_RESET = 32'h0000_0000;
  localparam logic [7:0] PAD_MARK = 8'h80;
  localparam logic [15:0] SV_COUNTER = 16'h0001;
  localparam logic [15:0] SV_LENGTH = 16'h0080;
  localparam logic [15:0] SV_LABEL = 16'h9669;
  localparam int CAP_RESILIENT_BIT = 1;
  localparam logic [4:0] FULL_BLOCK = 5'h10;

  typedef enum logic [1:0] {
    CMD_FIRST_P1,
    CMD_FOLLOW_P1,
    CMD_PART2,
    CMD_OTHER
  } cmd_kind_e;

  typedef struct packed {
    cmd_kind_e               kind;
    logic [KEY_W-1:0]        key_no;
    logic                    key_exists;
    logic                    len_cap_ok;
    logic [2:0]              cap_len;
    logic [CAP_BYTES*8-1:0]  reader_capabilities;
    logic [127:0]            reader_challenge;
  } cmd_s;

  typedef enum logic [2:0] {
    RSP_NONE,
    RSP_CHALLENGE,
    RSP_PART2,
    RSP_REJECT,
    RSP_ABORT,
    RSP_INTEGRITY,
    RSP_PASS
  } rsp_e;

  typedef enum logic [2:0] {
    OP_ROOT,
    OP_KEYS,
    OP_VERIFY,
    OP_ENCRYPT,
    OP_MAC
  } eng_op_e;

  typedef struct packed {
    logic          valid;
    eng_op_e       op;
    logic [255:0]  data;
  } eng_req_s;

endpackage

/* File: hdl/rsm_pad_unit.sv */
/*
  pads the last chunk of a message to whole 16-byte blocks.
  assumes the caller holds a chunk until ready; bytes sit msb first.
*/
`timescale 1ns/1ps
module rsm_pad_unit
  import rsm_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // chunk in
  input  wire logic          in_valid,
  input  wire logic [127:0]  in_data,
  input  wire logic [4:0]    in_count,
  input  wire logic          in_final,
  output logic               in_ready,
  // block out
  output logic               out_valid,
  output logic [127:0]       out_data
);

  logic extra;

  function automatic logic [127:0] pad_chunk(input logic [127:0] d,
                                             input logic [4:0] n);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < BLK_BYTES; i++)
    begin
      if (i < n)
        r[127-8*i -: 8] = d[127-8*i -: 8];
      else if (i == n)
        r[127-8*i -: 8] = PAD_MARK;
    end
    return r;
  endfunction

  assign in_ready = !extra;

  // an aligned final chunk still needs a whole block of padding
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      extra <= 1'b0;
    else if (extra)
      extra <= 1'b0;
    else if (in_valid && in_final && in_count == FULL_BLOCK)
      extra <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (extra)
    begin
      out_valid <= 1'b1;
      out_data  <= {PAD_MARK, 120'h0};
    end
    else if (in_valid)
    begin
      out_valid <= 1'b1;
      out_data  <= in_final ? pad_chunk(in_data, in_count) : in_data;
    end
    else
      out_valid <= 1'b0;
  end

endmodule

/* File: hdl/rsm_card.sv */
/*
  card-side login and session control of the resilient secure messaging.
  assumes a frame layer that decodes commands, a random source, and a
  crypto engine that runs the primitive on request; all on clk.
*/
`timescale 1ns/1ps
module rsm_card
  import rsm_pkg::*;
#(
  parameter logic [KEY_W-1:0] ORIGIN_KEY = 4'h0
)
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // decoded commands from the frame layer
  input  wire logic                    cmd_valid,
  input  wire cmd_s                    cmd,
  input  wire logic                    cmd_end,
  input  wire logic [CAP_BYTES*8-1:0]  card_capabilities,
  output rsp_e                         rsp,
  output logic                         rsp_valid,
  output logic [127:0]                 card_challenge,
  // random source
  input  wire logic                    rng_valid,
  input  wire logic [127:0]            rng_data,
  // crypto engine
  output eng_req_s                     eng_req,
  input  wire logic                    eng_done,
  input  wire logic                    eng_ok,
  input  wire logic [127:0]            mac_full,
  input  wire logic                    mac_full_valid,
  output logic [63:0]                  mac_short,
  // messaging blocks
  input  wire logic                    pt_valid,
  input  wire logic [127:0]            pt_data,
  input  wire logic [4:0]              pt_count,
  input  wire logic                    pt_final,
  output logic                         pt_ready,
  output logic                         blk_valid,
  output logic [127:0]                 blk_data,
  input  wire logic                    dec_blk,
  input  wire logic                    sm_fault,
  // session state
  output logic [CTR_W-1:0]             block_cipher_counter,
  output logic [CMD_CTR_W-1:0]         command_counter,
  output logic [TAG_BYTES*8-1:0]       transaction_tag,
  output logic                         authenticated
);

  if (TAG_BYTES + 2 * CAP_BYTES != BLK_BYTES)
    $error("tag and capabilities must fill one block");

  typedef enum {
    ST_IDLE,
    ST_RAND,
    ST_TAG,
    ST_WAIT_P2,
    ST_ROOT,
    ST_KEYS,
    ST_VERIFY,
    ST_ENC,
    ST_MAC
  } state_e;

  state_e                  state;
  logic                    follow;
  logic                    origin;
  logic [127:0]            reader_challenge;
  logic [CAP_BYTES*8-1:0]  reader_capabilities;
  logic [127:0]            reply_cipher;
  logic                    pad_ready;
  logic                    pad_valid;
  logic [127:0]            pad_data;
  logic                    in_login;
  logic                    blk_step;
  logic                    p1_ok;

  function automatic logic [255:0] session_vector(input logic [127:0] a,
                                                  input logic [127:0] b);
    return {SV_COUNTER, SV_LENGTH, a[127:112], a[111:64] ^ b[127:80],
            b[79:0], a[63:0], SV_LABEL};
  endfunction

  // bytes past the received length read as zero
  function automatic logic [CAP_BYTES*8-1:0] fit_caps(
    input logic [CAP_BYTES*8-1:0] c, input logic [2:0] n);
    logic [CAP_BYTES*8-1:0] r;
    r = '0;
    for (int i = 0; i < CAP_BYTES; i++)
    begin
      if (i < n)
        r[CAP_BYTES*8-1-8*i -: 8] = c[CAP_BYTES*8-1-8*i -: 8];
    end
    return r;
  endfunction

  // keep even-numbered bytes, most significant first
  function automatic logic [63:0] truncate_mac(input logic [127:0] m);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[63-8*i -: 8] = m[119-16*i -: 8];
    return r;
  endfunction

  assign in_login = state != ST_IDLE;
  // padded blocks and decrypted blocks advance the counter; one step only when both arrive in the same cycle
  assign blk_step = (pad_valid || dec_blk) && authenticated;

  // key must exist; follow-up needs a session or origin key
  // longer messages pass as long as the length capability checks
  always_comb
  begin
    p1_ok = cmd.key_exists && cmd.len_cap_ok;
    if (cmd.kind == CMD_FOLLOW_P1 && !authenticated
        && cmd.key_no != ORIGIN_KEY)
      p1_ok = 1'b0;
  end

  // padding stays out of the login, which ciphers whole blocks only
  // the pad path is closed while a login runs
  rsm_pad_unit u_pad (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (pt_valid && pt_ready && !in_login && authenticated),
    .in_data   (pt_data),
    .in_count  (pt_count),
    .in_final  (pt_final),
    .in_ready  (pad_ready),
    .out_valid (pad_valid),
    .out_data  (pad_data)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pt_ready  <= 1'b0;
      blk_valid <= 1'b0;
      blk_data  <= '0;
    end
    else
    begin
      // low after a taken aligned final: the pad block owns the next cycle
      pt_ready  <= pad_ready && !in_login && authenticated
                   && !(pt_valid && pt_ready && pt_final
                   && pt_count == FULL_BLOCK);
      blk_valid <= pad_valid;
      blk_data  <= pad_data;
    end
  end

  // login sequence
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state               <= ST_IDLE;
      follow              <= 1'b0;
      origin              <= 1'b0;
      reader_challenge    <= '0;
      reader_capabilities <= '0;
      card_challenge      <= '0;
      reply_cipher        <= '0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          // only bit 1 of the first capability byte is looked at
          if (cmd_valid && p1_ok && (cmd.kind == CMD_FOLLOW_P1
              || (cmd.kind == CMD_FIRST_P1
              && cmd.reader_capabilities[40+CAP_RESILIENT_BIT])))
          begin
            state               <= ST_RAND;
            follow              <= cmd.kind == CMD_FOLLOW_P1;
            origin              <= cmd.key_no == ORIGIN_KEY;
            reader_capabilities <= fit_caps(cmd.reader_capabilities,
                                            cmd.cap_len);
          end
        ST_RAND:
          if (rng_valid)
          begin
            card_challenge <= rng_data;
            state          <= follow ? ST_WAIT_P2 : ST_TAG;
          end
        ST_TAG:
          if (rng_valid)
            state <= ST_WAIT_P2;
        ST_WAIT_P2:
          // anything but part two with its length check passed ends the login
          if (cmd_valid)
          begin
            if (cmd.kind == CMD_PART2 && cmd.len_cap_ok)
            begin
              reader_challenge <= cmd.reader_challenge;
              state            <= ST_ROOT;
            end
            else
              state <= ST_IDLE;
          end
        ST_ROOT:
          if (eng_done)
            state <= ST_KEYS;
        ST_KEYS:
          if (eng_done)
            state <= ST_VERIFY;
        ST_VERIFY:
          // a wrong reader MAC refuses part two
          if (eng_done)
            state <= !eng_ok ? ST_IDLE : (follow ? ST_MAC : ST_ENC);
        ST_ENC:
          if (eng_done)
          begin
            reply_cipher <= mac_full;
            state        <= ST_MAC;
          end
        ST_MAC:
          if (eng_done)
            state <= ST_IDLE;
      endcase
    end
  end

  // engine requests held until done
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      eng_req <= '{valid: 1'b0, op: OP_ROOT, data: '0};
    else if (eng_done)
      eng_req.valid <= 1'b0;
    else
    begin
      unique case (state)
        ST_ROOT:
          // root key is the MAC of the vector under the static key
          eng_req <= '{valid: 1'b1, op: OP_ROOT,
                       data: session_vector(reader_challenge,
                                            card_challenge)};
        ST_KEYS:
          // plaintext set, then integrity and cipher updated keys
          eng_req <= '{valid: 1'b1, op: OP_KEYS, data: '0};
        ST_VERIFY:
          // reader MAC over its challenge then the card's, untruncated
          eng_req <= '{valid: 1'b1, op: OP_VERIFY,
                       data: {reader_challenge, card_challenge}};
        ST_ENC:
          // tag, card capabilities, echoed reader capabilities
          eng_req <= '{valid: 1'b1, op: OP_ENCRYPT,
                       data: {transaction_tag, card_capabilities,
                              reader_capabilities, 128'h0}};
        ST_MAC:
          // card challenge, xored with the cipher text on a first login, then reader challenge
          eng_req <= '{valid: 1'b1, op: OP_MAC,
                       data: follow
                             ? {card_challenge, reader_challenge}
                             : {card_challenge ^ reply_cipher,
                                reader_challenge}};
        default:
          eng_req.valid <= 1'b0;
      endcase
    end
  end

  // counter drives the key stream msb first, unsigned
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      block_cipher_counter <= CTR_RESET;
    else if (state == ST_IDLE && cmd_valid && p1_ok
             && (cmd.kind == CMD_FOLLOW_P1 || (cmd.kind == CMD_FIRST_P1
             && cmd.reader_capabilities[40+CAP_RESILIENT_BIT])))
      block_cipher_counter <= CTR_RESET;
    // a first login's part-two reply uses value zero, so its messaging starts at one
    else if (state == ST_ENC && eng_done)
      block_cipher_counter <= block_cipher_counter + CTR_STEP;
    else if (blk_step)
      block_cipher_counter <= block_cipher_counter + CTR_STEP;
  end

  // first login zeros command counter and draws a fresh tag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      command_counter <= CMD_CTR_RESET;
      transaction_tag <= TAG_RESET;
    end
    else if (state == ST_TAG && rng_valid)
    begin
      command_counter <= CMD_CTR_RESET;
      transaction_tag <= rng_data[TAG_BYTES*8-1:0];
    end
    else if (cmd_end && authenticated && !in_login)
      command_counter <= command_counter + 16'h0001;
  end

  // session state; origin key never leaves the card authenticated
  // while set, both modes run with the resilient algorithms
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      authenticated <= 1'b0;
    else if (state == ST_MAC && eng_done)
      authenticated <= !origin;
    // integrity fault drops the session at once
    else if (sm_fault && !in_login)
      authenticated <= 1'b0;
    else if (state == ST_IDLE && cmd_valid
             && (cmd.kind == CMD_FOLLOW_P1 || cmd.kind == CMD_PART2
             || (cmd.kind == CMD_FIRST_P1
             && cmd.reader_capabilities[40+CAP_RESILIENT_BIT])))
      authenticated <= 1'b0;
    else if (state == ST_WAIT_P2 && cmd_valid)
      authenticated <= 1'b0;
  end

  // answers to the frame layer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp       <= RSP_NONE;
      rsp_valid <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b1;
      if (state == ST_IDLE && cmd_valid)
      begin
        unique case (cmd.kind)
          CMD_FIRST_P1:
            rsp <= !cmd.reader_capabilities[40+CAP_RESILIENT_BIT]
                   ? RSP_PASS : (p1_ok ? RSP_NONE : RSP_REJECT);
          CMD_FOLLOW_P1:
            rsp <= p1_ok ? RSP_NONE : RSP_REJECT;
          CMD_PART2:
            rsp <= RSP_REJECT;
          CMD_OTHER:
            rsp <= RSP_PASS;
        endcase
        rsp_valid <= !(p1_ok && cmd.kind == CMD_FOLLOW_P1)
                     && !(p1_ok && cmd.kind == CMD_FIRST_P1
                     && cmd.reader_capabilities[40+CAP_RESILIENT_BIT]);
      end
      else if (state == ST_TAG && rng_valid
               || state == ST_RAND && rng_valid && follow)
        rsp <= RSP_CHALLENGE;
      else if (state == ST_WAIT_P2 && cmd_valid)
        rsp <= (cmd.kind == CMD_PART2 && cmd.len_cap_ok)
               ? RSP_NONE : RSP_ABORT;
      else if (state == ST_VERIFY && eng_done && !eng_ok)
        rsp <= RSP_REJECT;
      else if (state == ST_MAC && eng_done)
        rsp <= RSP_PART2;
      else if (sm_fault && !in_login)
        rsp <= RSP_INTEGRITY;
      else
      begin
        rsp       <= RSP_NONE;
        rsp_valid <= 1'b0;
      end
      if (state == ST_WAIT_P2 && cmd_valid && cmd.kind == CMD_PART2
          && cmd.len_cap_ok)
        rsp_valid <= 1'b0;
    end
  end

  // truncated MAC for messaging, not for login replies
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mac_short <= '0;
    else if (mac_full_valid && !in_login)
      mac_short <= truncate_mac(mac_full);
  end

endmodule

/* File: test/rsm_engine_model.sv */
/*
  crypto engine model behind rsm_card: one answer per request.
  assumes eng_req is held until eng_done; slow adds wait states.
*/
`timescale 1ns/1ps
module rsm_engine_model
  import rsm_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // card engine port
  input  wire eng_req_s eng_req,
  input  wire logic     slow,
  input  wire logic     bad_mac,
  input  wire logic     msg_mac,
  output logic          eng_done,
  output logic          eng_ok,
  output logic [127:0]  mac_full,
  output logic          mac_full_valid
);
  logic [2:0] wait_n;
  logic       gap;

  // answer each step; verify fails on request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_n <= 3'h0;
      gap <= 1'b0;
      eng_done <= 1'b0;
      eng_ok <= 1'b0;
      mac_full <= 128'h0;
      mac_full_valid <= 1'b0;
    end
    else
    begin
      eng_done <= 1'b0;
      mac_full_valid <= 1'b0;
      // result bus does not hold its last value
      mac_full <= ~mac_full;
      gap <= 1'b0;
      if (eng_req.valid && !gap)
      begin
        wait_n <= wait_n + 3'h1;
        if (wait_n == (slow ? 3'h5 : 3'h1))
        begin
          wait_n <= 3'h0;
          gap <= 1'b1;
          eng_done <= 1'b1;
          eng_ok <= !(bad_mac && eng_req.op == OP_VERIFY);
          mac_full <= eng_req.data[255:128] ^ eng_req.data[127:0];
          mac_full_valid <= eng_req.op == OP_MAC;
        end
      end
      // a messaging MAC arrives with no request pending
      if (msg_mac && !eng_req.valid)
      begin
        mac_full_valid <= 1'b1;
        mac_full <= 128'h00112233445566778899AABBCCDDEEFF;
      end
    end
  end
endmodule

/* File: test/rsm_card_asserts.sv */
/*
  checker on the rsm_card ports, bound below.
  one clock, asynchronous reset rst.
*/
`timescale 1ns/1ps
module rsm_card_asserts
  import rsm_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // watched ports
  input wire rsp_e         rsp,
  input wire logic         rsp_valid,
  input wire eng_req_s     eng_req,
  input wire logic [127:0] mac_full,
  input wire logic         mac_full_valid,
  input wire logic [63:0]  mac_short,
  input wire logic         pt_valid,
  input wire logic [127:0] pt_data,
  input wire logic [4:0]   pt_count,
  input wire logic         pt_final,
  input wire logic         pt_ready,
  input wire logic         blk_valid,
  input wire logic [127:0] blk_data,
  input wire logic         sm_fault,
  input wire logic [31:0]  block_cipher_counter,
  input wire logic [15:0]  command_counter,
  input wire logic [31:0]  transaction_tag,
  input wire logic         authenticated
);
  function automatic logic [63:0] evb(logic [127:0] m);
    for (int i = 0; i < 8; i++)
      evb[63-8*i -: 8] = m[119-16*i -: 8];
  endfunction

  function automatic logic [127:0] padx(logic [127:0] d, logic [4:0] n);
    return (d & ~({128{1'b1}} >> (8 * n))) | (128'h80 << (8 * (15 - n)));
  endfunction

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ctr_zero_a: assert property (
    rsp_valid && rsp == RSP_CHALLENGE |-> block_cipher_counter == CTR_RESET)
    else $error("counter not zero at challenge");
  rst_clear_a: assert property (disable iff (1'b0) rst |->
    !authenticated && block_cipher_counter == 0 && command_counter == 0 &&
    transaction_tag == 0) else $error("state not cleared in reset");
  sv_frame_a: assert property (
    $rose(eng_req.valid) && eng_req.op == OP_ROOT |->
    eng_req.data[255:224] == {SV_COUNTER, SV_LENGTH} &&
    eng_req.data[15:0] == SV_LABEL) else $error("session vector frame");
  mac_trunc_a: assert property (
    mac_full_valid && !eng_req.valid |=> mac_short == evb($past(mac_full)))
    else $error("short mac not even bytes");
  short_pad_a: assert property (
    pt_valid && pt_ready && pt_final && pt_count < FULL_BLOCK |-> ##2
    blk_valid && blk_data == padx($past(pt_data, 2), $past(pt_count, 2)))
    else $error("short chunk padding");
  auth_cause_a: assert property (
    $rose(authenticated) |-> rsp_valid && rsp == RSP_PART2)
    else $error("auth without part two reply");
  fault_drop_a: assert property (
    sm_fault && authenticated |=>
    rsp_valid && rsp == RSP_INTEGRITY && !authenticated)
    else $error("fault not answered");
  abort_drop_a: assert property (
    rsp_valid && rsp == RSP_ABORT |-> !authenticated)
    else $error("abort kept auth");

  cover property (rsp_valid && rsp == RSP_PART2);
  cover property (rsp_valid && rsp == RSP_INTEGRITY);
  cover property (blk_valid && blk_data == {PAD_MARK, 120'h0});
endmodule

bind rsm_card rsm_card_asserts chk (.clk, .rst, .rsp, .rsp_valid, .eng_req,
  .mac_full, .mac_full_valid, .mac_short, .pt_valid, .pt_data, .pt_count,
  .pt_final, .pt_ready, .blk_valid, .blk_data, .sm_fault,
  .block_cipher_counter, .command_counter, .transaction_tag,
  .authenticated);

/* File: test/testbench.sv */
/*
  self-checking bench for rsm_card with the engine model.
  the bench plays frame layer and random source; 125 MHz clock.
*/
`timescale 1ns/1ps
module testbench
  import rsm_pkg::*;
;
  logic         clk, rst, cmd_valid, cmd_end, rng_valid, rsp_valid;
  logic         eng_done, eng_ok, mac_full_valid, pt_valid, pt_final;
  logic         pt_ready, blk_valid, dec_blk, sm_fault, authenticated;
  logic         slow, bad_mac, msg_mac;
  cmd_s         cmd;
  rsp_e         rsp;
  eng_req_s     eng_req;
  logic [127:0] card_challenge, rng_data, mac_full, pt_data, blk_data;
  logic [127:0] last_blk;
  logic [255:0] root_seen, enc_seen;
  logic [63:0]  mac_short;
  logic [47:0]  card_capabilities;
  logic [31:0]  block_cipher_counter, transaction_tag;
  logic [15:0]  command_counter;
  logic [4:0]   pt_count;
  int           bad_count, checks_done, blk_cnt, cycles;

  rsm_card #(.ORIGIN_KEY(4'h0)) dut (.clk, .rst, .cmd_valid, .cmd, .cmd_end,
    .card_capabilities, .rsp, .rsp_valid, .card_challenge, .rng_valid,
    .rng_data, .eng_req, .eng_done, .eng_ok, .mac_full, .mac_full_valid,
    .mac_short, .pt_valid, .pt_data, .pt_count, .pt_final, .pt_ready,
    .blk_valid, .blk_data, .dec_blk, .sm_fault, .block_cipher_counter,
    .command_counter, .transaction_tag, .authenticated);
  rsm_engine_model eng (.clk, .rst, .eng_req, .slow, .bad_mac, .msg_mac,
    .eng_done, .eng_ok, .mac_full, .mac_full_valid);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (eng_req.valid && eng_req.op == OP_ROOT)
      root_seen <= eng_req.data;
    if (eng_req.valid && eng_req.op == OP_ENCRYPT)
      enc_seen <= eng_req.data;
    if (blk_valid)
    begin
      blk_cnt <= blk_cnt + 1;
      last_blk <= blk_data;
    end
    // a hang ends the run as a mismatch
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic check(string nm, logic [255:0] seen, logic [255:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic send(cmd_kind_e k);
    cmd.kind = k;
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
  endtask

  task automatic expect_rsp(logic [2:0] e);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200)
    begin
      step();
      n++;
    end
    // the reader takes the first valid reply and compares it with the one it waits for
    check("rsp", rsp, e);
    step();
  endtask

  // the second word of a first login becomes the tag
  task automatic begin_login(cmd_kind_e k, logic two);
    send(k);
    step();
    rng_valid = 1'b1;
    rng_data = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    step();
    if (two)
    begin
      rng_data = 128'hC0DE0001;
      step();
    end
    rng_valid = 1'b0;
    expect_rsp(RSP_CHALLENGE);
    check("enc_ctr", block_cipher_counter, 0);
    check("challenge", card_challenge, 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0);
  endtask

  task automatic first_login(logic [47:0] rc, logic [2:0] n, logic bad);
    logic [127:0] rb, ra;
    rb = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    ra = 128'h112233445566778899AABBCCDDEEFF00;
    cmd.key_no = 4'h1;
    cmd.reader_capabilities = rc;
    cmd.cap_len = n;
    cmd.reader_challenge = ra;
    bad_mac = bad;
    begin_login(CMD_FIRST_P1, 1'b1);
    check("tag", transaction_tag, 32'hC0DE0001);
    check("cmd_ctr", command_counter, 0);
    send(CMD_PART2);
    expect_rsp(bad ? RSP_REJECT : RSP_PART2);
    check("auth", authenticated, !bad);
    check("sv", root_seen, {SV_COUNTER, SV_LENGTH, ra[127:112],
      ra[111:64] ^ rb[127:80], rb[79:0], ra[63:0], SV_LABEL});
    if (!bad)
    begin
      check("ctr", block_cipher_counter, 1);
      check("ciph", enc_seen[255:128], {32'hC0DE0001, card_capabilities,
        rc & ~(48'hFFFFFFFFFFFF >> (8 * n))});
    end
    $display("login done");
  endtask

  task automatic refuse(cmd_kind_e k, logic ex, logic lc, logic [2:0] e);
    cmd.key_exists = ex;
    cmd.len_cap_ok = lc;
    send(k);
    expect_rsp(e);
  endtask

  task automatic t_refusals();
    cmd.key_no = 4'h1;
    // other bits of the first capability byte set, selection bit clear
    cmd.reader_capabilities = 48'hFD0000000000;
    refuse(CMD_FIRST_P1, 1'b1, 1'b1, RSP_PASS);
    cmd.reader_capabilities = 48'h020000000000;
    refuse(CMD_FIRST_P1, 1'b0, 1'b1, RSP_REJECT);
    refuse(CMD_FIRST_P1, 1'b1, 1'b0, RSP_REJECT);
    refuse(CMD_FOLLOW_P1, 1'b1, 1'b1, RSP_REJECT);
    refuse(CMD_PART2, 1'b1, 1'b1, RSP_REJECT);
    begin_login(CMD_FIRST_P1, 1'b1);
    send(CMD_OTHER);
    expect_rsp(RSP_ABORT);
    check("auth", authenticated, 0);
    $display("refusals done");
  endtask

  task automatic chunk(logic [127:0] d, logic [4:0] n, logic f, int b);
    int k;
    pt_valid = 1'b1;
    pt_data = d;
    pt_count = n;
    pt_final = f;
    k = 0;
    // taken at the first edge that samples pt_ready high
    while (pt_ready !== 1'b1 && k < 50)
    begin
      step();
      k++;
    end
    step();
    pt_valid = 1'b0;
    while (blk_cnt != b && k < 50)
    begin
      step();
      k++;
    end
    step();
  endtask

  task automatic t_messaging();
    check("blocks", blk_cnt, 0);
    chunk(128'hA0, 5'h10, 1'b0, 1);
    chunk(128'hA1, 5'h10, 1'b1, 3);
    check("pad", last_blk, {PAD_MARK, 120'h0});
    check("ctr", block_cipher_counter, 4);
    chunk({40'hDEADBEEF01, 88'h5}, 5'h5, 1'b1, 4);
    check("pad5", last_blk, {40'hDEADBEEF01, PAD_MARK, 80'h0});
    dec_blk = 1'b1;
    cmd_end = 1'b1;
    msg_mac = 1'b1;
    step();
    dec_blk = 1'b0;
    cmd_end = 1'b0;
    msg_mac = 1'b0;
    step();
    check("ctr", block_cipher_counter, 6);
    check("cmd_ctr", command_counter, 1);
    check("mac", mac_short, 64'h1133557799BBDDFF);
    sm_fault = 1'b1;
    step();
    sm_fault = 1'b0;
    expect_rsp(RSP_INTEGRITY);
    check("auth", authenticated, 0);
    $display("messaging done");
  endtask

  task automatic t_followup(logic [3:0] key, logic a);
    logic [31:0] tg;
    logic [15:0] cc;
    tg = transaction_tag;
    cc = command_counter;
    cmd.key_no = key;
    begin_login(CMD_FOLLOW_P1, 1'b0);
    send(CMD_PART2);
    expect_rsp(RSP_PART2);
    check("auth", authenticated, a);
    check("tag", transaction_tag, tg);
    check("cmd_ctr", command_counter, cc);
    check("ctr", block_cipher_counter, 0);
    $display("followup done");
  endtask

  initial
  begin
    {rst, slow, bad_mac, msg_mac} = 4'b1000;
    {cmd_valid, cmd_end, rng_valid, pt_valid, pt_final, dec_blk} = 6'h0;
    sm_fault = 1'b0;
    cmd = '0;
    rng_data = 128'h0;
    pt_data = 128'h0;
    pt_count = 5'h10;
    card_capabilities = 48'hC1C2C3C4C5C6;
    {bad_count, checks_done, blk_cnt, cycles} = '0;
    repeat (8) @(posedge clk);
    #1;
    check("rst_auth", authenticated, 0);
    rst = 1'b0;
    t_refusals();
    first_login(48'h02ABCDEF1234, 3'h3, 1'b1);
    first_login(48'h02ABCDEF1234, 3'h3, 1'b0);
    t_messaging();
    t_followup(4'h0, 1'b0);
    slow = 1'b1;
    first_login(48'h020000000000, 3'h6, 1'b0);
    t_followup(4'h1, 1'b1);
    give_verdict();
  end
endmodule
